// ---- core/usc_sof_config.sv ----
`timescale 1ns/1ps
`include "usc_consts.svh"

// How it works
// - Threshold holds ten plus largest packet bytes
// - Threshold acts only in host mode
// - Upper byte reads zero, ignores writes
// - Transceiver disable makes the indication follow line drive, whatever the monitor bit
// - Bit seven enables eye-pattern test
module usc_sof_config
  import usc_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // Engine status
  input wire logic HOST_MODE,
  input wire logic [15:0] BYTES_TO_SOF,
  input wire logic TOKEN_REQ,
  input wire logic LINE_DRIVE,
  input wire logic TRANSCEIVER_DISABLE,
  // Controls
  output logic TOKEN_GO,
  output logic OE_N,
  output logic EYE_PATTERN_TEST_ENABLE,
  output logic STOP_IN_IDLE,
  output logic [1:0] PINGPONG_BUFFER_MODE
);

  // ----------------------------------------
  // Usage notes
  // ----------------------------------------
  // The threshold is a plain byte count; the engine supplies byte times
  // left before the next frame start, so no scaling happens here.
  // The transceiver disable bit lives in another register and arrives
  // as a level; this block reports its effect on the indication and returns the level in the status word.
  // Every output is registered, which costs one cycle of latency but
  // keeps the engine free of decode glitches.

  // ----------------------------------------
  // Constants
  // ----------------------------------------
  // Held as vectors so single fields of a reset value can be picked out
  localparam logic [7:0] SOF_RESET = `USC_SOF_RESET;
  localparam logic [7:0] CFG_RESET = `USC_CFG_RESET;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // One place decides whether a strobe hits a register index
  function automatic logic reg_hit(
    input logic strobe,
    input logic [3:0] addr,
    input logic [3:0] index
  );
    reg_hit = strobe && (addr == index);
  endfunction : reg_hit

  // The upper byte of every register is unimplemented
  function automatic logic [15:0] low_byte_word(
    input logic [7:0] value
  );
    low_byte_word = {8'h00, value};
  endfunction : low_byte_word

  // Status word: transceiver disable, host mode and last token grant
  function automatic logic [15:0] status_word(
    input logic disable_bit,
    input logic host_bit,
    input logic grant_bit
  );
    status_word = {13'h0, disable_bit, host_bit, grant_bit};
  endfunction : status_word

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] threshold_count_field_reg;
  logic [7:0] threshold_count_field_next;

  logic eye_pattern_test_enable_reg;
  logic eye_pattern_test_enable_next;

  logic output_enable_monitor_enable_reg;
  logic output_enable_monitor_enable_next;

  logic stop_in_idle_reg;
  logic stop_in_idle_next;

  usc_ppb_type pingpong_buffer_mode_reg;
  usc_ppb_type pingpong_buffer_mode_next;

  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  logic oe_n_reg;
  logic oe_n_next;

  logic token_go_reg;
  logic token_go_next;

  // ----------------------------------------
  // Decoded and derived values
  // ----------------------------------------
  logic threshold_write;
  logic config_write;
  logic threshold_read;
  logic config_read;
  logic status_read;
  logic [7:0] config_one_view;
  logic [15:0] bytes_threshold;
  logic withhold;
  logic line_drive_reported;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  // An unmapped index hits nothing, so such a write is simply lost
  always_comb begin
    threshold_write = 1'b0;
    config_write = 1'b0;
    if (reg_hit(WR, ADDR, `USC_ADDR_SOF_THRESHOLD)) begin
      threshold_write = 1'b1;
    end else if (reg_hit(WR, ADDR, `USC_ADDR_CONFIG_ONE)) begin
      config_write = 1'b1;
    end
  end

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  // An unmapped index selects nothing, so the read returns zero
  always_comb begin
    threshold_read = 1'b0;
    config_read = 1'b0;
    status_read = 1'b0;
    if (reg_hit(RD, ADDR, `USC_ADDR_SOF_THRESHOLD)) begin
      threshold_read = 1'b1;
    end else if (reg_hit(RD, ADDR, `USC_ADDR_CONFIG_ONE)) begin
      config_read = 1'b1;
    end else if (reg_hit(RD, ADDR, `USC_ADDR_STATUS)) begin
      status_read = 1'b1;
    end
  end

  // Bits 5, 3 and 2 have no storage and read zero
  always_comb begin
    config_one_view = 8'h00;
    config_one_view[`USC_BIT_EYE] = eye_pattern_test_enable_reg;
    config_one_view[`USC_BIT_OEMON] = output_enable_monitor_enable_reg;
    config_one_view[`USC_BIT_SIDL] = stop_in_idle_reg;
    config_one_view[1:0] = pingpong_buffer_mode_reg;
  end

  // ----------------------------------------
  // Threshold register
  // ----------------------------------------
  // Only the low byte is stored; the upper byte of a write is dropped
  always_comb begin
    threshold_count_field_next = threshold_count_field_reg;
    if (threshold_write) begin
      threshold_count_field_next = WDATA[7:0];
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      threshold_count_field_reg <= SOF_RESET;
    end else begin
      threshold_count_field_reg <= threshold_count_field_next;
    end
  end

  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  // Written as a whole byte; unimplemented bits are simply not kept
  always_comb begin
    eye_pattern_test_enable_next = eye_pattern_test_enable_reg;
    output_enable_monitor_enable_next = output_enable_monitor_enable_reg;
    stop_in_idle_next = stop_in_idle_reg;
    pingpong_buffer_mode_next = pingpong_buffer_mode_reg;
    if (config_write) begin
      eye_pattern_test_enable_next = WDATA[`USC_BIT_EYE];
      output_enable_monitor_enable_next = WDATA[`USC_BIT_OEMON];
      stop_in_idle_next = WDATA[`USC_BIT_SIDL];
      pingpong_buffer_mode_next = usc_ppb_type'(WDATA[1:0]);
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      eye_pattern_test_enable_reg <= CFG_RESET[`USC_BIT_EYE];
      output_enable_monitor_enable_reg <= CFG_RESET[`USC_BIT_OEMON];
      stop_in_idle_reg <= CFG_RESET[`USC_BIT_SIDL];
      pingpong_buffer_mode_reg <= usc_ppb_type'(CFG_RESET[1:0]);
    end else begin
      eye_pattern_test_enable_reg <= eye_pattern_test_enable_next;
      output_enable_monitor_enable_reg <= output_enable_monitor_enable_next;
      stop_in_idle_reg <= stop_in_idle_next;
      pingpong_buffer_mode_reg <= pingpong_buffer_mode_next;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Read data stand in the cycle after the strobe only, zero otherwise
  always_comb begin
    rdata_next = 16'h0000;
    if (threshold_read) begin
      rdata_next = low_byte_word(threshold_count_field_reg);
    end else if (config_read) begin
      rdata_next = low_byte_word(config_one_view);
    end else if (status_read) begin
      rdata_next = status_word(TRANSCEIVER_DISABLE, HOST_MODE, token_go_reg);
    end
  end

  // Clearing after one cycle lets the bus be read as an OR of slaves
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------
  // Token gating
  // ----------------------------------------
  // Widened so the compare runs on byte times
  assign bytes_threshold = low_byte_word(threshold_count_field_reg);

  // Device mode never withholds: the threshold is a host-only setting
  always_comb begin
    withhold = 1'b0;
    if (HOST_MODE) begin
      withhold = BYTES_TO_SOF < bytes_threshold;
    end
    token_go_next = TOKEN_REQ && !withhold;
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      token_go_reg <= 1'b0;
    end else begin
      token_go_reg <= token_go_next;
    end
  end

  // ----------------------------------------
  // Output-enable indication
  // ----------------------------------------
  // Disable overrides monitor so external transceivers see drive
  always_comb begin
    line_drive_reported = 1'b0;
    if (TRANSCEIVER_DISABLE) begin
      line_drive_reported = LINE_DRIVE;
    end else if (output_enable_monitor_enable_reg) begin
      line_drive_reported = LINE_DRIVE;
    end
    oe_n_next = !line_drive_reported;
  end

  // Idles high so nothing outside sees a drive during reset
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      oe_n_reg <= 1'b1;
    end else begin
      oe_n_reg <= oe_n_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign RDATA = rdata_reg;
  assign OE_N = oe_n_reg;
  assign TOKEN_GO = token_go_reg;
  assign EYE_PATTERN_TEST_ENABLE = eye_pattern_test_enable_reg;
  assign STOP_IN_IDLE = stop_in_idle_reg;
  assign PINGPONG_BUFFER_MODE = pingpong_buffer_mode_reg;

endmodule : usc_sof_config

// ---- core/usc_consts.svh ----
`ifndef USC_CONSTS_SVH
`define USC_CONSTS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define USC_ADDR_SOF_THRESHOLD 4'h0
`define USC_ADDR_CONFIG_ONE 4'h1
`define USC_ADDR_STATUS 4'h2

// ----------------------------------------
// Field positions
// ----------------------------------------
`define USC_BIT_EYE 7
`define USC_BIT_OEMON 6
`define USC_BIT_SIDL 4
`define USC_CFG_WR_MASK 8'hd3

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define USC_SOF_RESET 8'h00
`define USC_CFG_RESET 8'h00
`define USC_SOF_OVERHEAD 8'h0a

`endif

// ---- core/usc_pkg.sv ----
package usc_pkg;
  typedef enum logic [1:0] {
    USC_PPB_NONE = 2'b00,
    USC_PPB_EP0_OUT = 2'b01,
    USC_PPB_ALL = 2'b10,
    USC_PPB_EP1_15 = 2'b11
  } usc_ppb_type;
endpackage : usc_pkg

// ---- bench/usc_sof_config_assertions.sv ----
`timescale 1ns/1ps
module usc_chk (
  input wire logic CLOCK, RST, WR, RD, HOST_MODE, TOKEN_REQ, LINE_DRIVE, TRANSCEIVER_DISABLE,
  input wire logic TOKEN_GO, OE_N, EYE_PATTERN_TEST_ENABLE, STOP_IN_IDLE,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA, RDATA, BYTES_TO_SOF,
  input wire logic [1:0] PINGPONG_BUFFER_MODE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // Shadow of the threshold, so the gate can be judged without the bus
  logic [7:0] thr_reg;
  always_ff @(posedge CLOCK or posedge RST)
    if (RST) thr_reg <= 8'h00;
    else if (WR && ADDR == 4'h0) thr_reg <= WDATA[7:0];
  rd_upper_a: assert property (RD |=> RDATA[15:8] == 8'h00) else $error("upper byte set");
  rd_idle_a: assert property (!RD |=> RDATA == 16'h0000) else $error("rdata not idle");
  eye_bit_a: assert property (WR && ADDR == 4'h1 |=> EYE_PATTERN_TEST_ENABLE == $past(WDATA[7]))
    else $error("eye bit");
  cfg_bits_a: assert property (WR && ADDR == 4'h1 |=> {STOP_IN_IDLE, PINGPONG_BUFFER_MODE} ==
    {$past(WDATA[4]), $past(WDATA[1:0])}) else $error("cfg bits");
  oe_idle_a: assert property (!LINE_DRIVE |=> OE_N) else $error("oe without drive");
  oe_force_a: assert property (TRANSCEIVER_DISABLE && LINE_DRIVE |=> !OE_N) else $error("oe forced");
  tok_dev_a: assert property (!HOST_MODE && TOKEN_REQ |=> TOKEN_GO) else $error("device gate");
  tok_thr_a: assert property (HOST_MODE |=> TOKEN_GO == ($past(TOKEN_REQ) &&
    $past(BYTES_TO_SOF) >= {8'h00, $past(thr_reg)})) else $error("token gate");
  cover property (WR && ADDR == 4'h0);
  cover property (HOST_MODE && TOKEN_REQ ##1 !TOKEN_GO);
  cover property (LINE_DRIVE ##1 !OE_N);
endmodule : usc_chk
bind usc_sof_config usc_chk u_usc_chk (.*);

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
  import usc_pkg::*;
  logic CLOCK = 1'h0, RST = 1'h1, WR = 1'h0, RD = 1'h0, HOST_MODE = 1'h0, TOKEN_REQ = 1'h0;
  logic LINE_DRIVE = 1'h0, TRANSCEIVER_DISABLE = 1'h0, TOKEN_GO, OE_N, EYE_PATTERN_TEST_ENABLE, STOP_IN_IDLE;
  logic [3:0] ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0, BYTES_TO_SOF = 16'h0, RDATA, d;
  logic [1:0] PINGPONG_BUFFER_MODE;
  logic [7:0] t;
  int failures = 0, comparisons = 0;
  int sz[3] = '{64, 32, 8};
  usc_sof_config u_usc_sof_config (.*);
  always #4 CLOCK = ~CLOCK;
  function logic tok_exp(logic [7:0] th);
    return TOKEN_REQ && !(HOST_MODE && BYTES_TO_SOF < {8'h00, th});
  endfunction : tok_exp
  task cmp(string n, logic [15:0] e, logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h saw %h", n, e, s);
    end
  endtask : cmp
  // Read data stand only one cycle, so the caller compares right after return
  task bus(logic w, logic [3:0] a, logic [15:0] v);
    @(posedge CLOCK);
    {WR, RD, ADDR, WDATA} <= {w, !w, a, v};
    @(posedge CLOCK);
    {WR, RD} <= 2'h0;
    #1;
  endtask : bus
  task step(logic h, logic q, logic l, logic x, logic [15:0] b);
    @(posedge CLOCK);
    {HOST_MODE, TOKEN_REQ, LINE_DRIVE, TRANSCEIVER_DISABLE, BYTES_TO_SOF} <= {h, q, l, x, b};
    @(posedge CLOCK);
    #1;
  endtask : step
  task complete_run;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  initial begin
    #400000;
    failures++;
    complete_run;
  end
  initial begin
    void'($urandom(32'hb10a));
    repeat (10) @(posedge CLOCK);
    RST <= 1'h0;
    cmp("oe reset", 16'h1, 16'(OE_N));
    bus(1'h0, 4'h5, 16'h0);
    cmp("unmapped", 16'h0, RDATA);
    foreach (sz[i]) begin
      t = 8'h0a + 8'(sz[i]);
      bus(1'h1, 4'h0, {8'hff, t});
      bus(1'h0, 4'h0, 16'h0);
      cmp("threshold", {8'h00, t}, RDATA);
      for (int j = 0; j < 3; j++) begin
        step(j != 2, 1'h1, 1'h0, 1'h0, {8'h00, t} - 16'(j != 1));
        cmp("token", 16'(tok_exp(t)), 16'(TOKEN_GO));
      end
    end
    $display("test threshold done");
    repeat (24) begin
      d = 16'($urandom);
      bus(1'h1, 4'h1, d);
      cmp("cfg out", 16'({d[7], d[4], d[1:0]}), 16'({EYE_PATTERN_TEST_ENABLE, STOP_IN_IDLE, PINGPONG_BUFFER_MODE}));
      bus(1'h0, 4'h1, 16'h0);
      cmp("cfg read", d & 16'h00d3, RDATA);
      // Power enable lives outside this block, so disable may move freely
      step(1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), 16'($urandom % 32));
      cmp("oe", 16'(!(LINE_DRIVE && (d[6] || TRANSCEIVER_DISABLE))), 16'(OE_N));
      cmp("token", 16'(tok_exp(t)), 16'(TOKEN_GO));
      bus(1'h0, 4'h2, 16'h0);
      cmp("status", {13'h0, TRANSCEIVER_DISABLE, HOST_MODE, tok_exp(t)}, RDATA);
    end
    $display("test random done");
    complete_run;
  end
endmodule : tb
